// File: dsp_cpu_pkg.sv
// Constants for the CPU programmer's model block
package dsp_cpu_pkg;
	localparam int DATA_W = 16;
	localparam int INSTR_W = 24;
	localparam int PC_W = 23;
	localparam int ACC_W = 40;
	localparam int NUM_W = 16;
	localparam int PAGE_W = 11;
	localparam int PWIN_PG_W = 9;
	localparam int BASE_W = 13;
	localparam int PWIN_OFF_W = 11;
	// Register word indices; byte address is index times four
	localparam logic [5:0] IDX_W0 = 6'h00;
	localparam logic [5:0] IDX_ACC0_L = 6'h10;
	localparam logic [5:0] IDX_ACC0_H = 6'h11;
	localparam logic [5:0] IDX_ACC0_U = 6'h12;
	localparam logic [5:0] IDX_ACC1_L = 6'h13;
	localparam logic [5:0] IDX_ACC1_H = 6'h14;
	localparam logic [5:0] IDX_ACC1_U = 6'h15;
	localparam logic [5:0] IDX_PC_L = 6'h16;
	localparam logic [5:0] IDX_PC_H = 6'h17;
	localparam logic [5:0] IDX_FLAGS = 6'h18;
	localparam logic [5:0] IDX_STKLIM = 6'h19;
	localparam logic [5:0] IDX_TBLPG = 6'h1a;
	localparam logic [5:0] IDX_RDPG = 6'h1b;
	localparam logic [5:0] IDX_WRPG = 6'h1c;
	localparam logic [5:0] IDX_RCNT = 6'h1d;
	localparam logic [5:0] IDX_DCNT = 6'h1e;
	localparam logic [5:0] IDX_LS_H = 6'h1f;
	localparam logic [5:0] IDX_LS_L = 6'h20;
	localparam logic [5:0] IDX_LE_H = 6'h21;
	localparam logic [5:0] IDX_LE_L = 6'h22;
	localparam logic [5:0] IDX_CORE = 6'h23;
	localparam logic [5:0] IDX_XMS = 6'h24;
	localparam logic [5:0] IDX_XME = 6'h25;
	localparam logic [5:0] IDX_YMS = 6'h26;
	localparam logic [5:0] IDX_YME = 6'h27;
	localparam logic [5:0] IDX_MCTL = 6'h28;
	localparam logic [5:0] IDX_BREV = 6'h29;
	localparam logic [5:0] IDX_LCMD = 6'h2a;
	localparam logic [5:0] IDX_STAT = 6'h2b;
	// Field positions
	localparam int FLG_DA = 9;
	localparam int FLG_RA = 4;
	localparam int CORE_PWIN = 2;
	localparam int MCTL_XM = 0;
	localparam int MCTL_YM = 1;
	localparam int MCTL_BR = 2;
	localparam int STAT_STK = 0;
	// Reset values and step sizes
	localparam logic [15:0] SP_RST = 16'h1000;
	localparam logic [15:0] STKLIM_RST = 16'hffff;
	localparam logic [15:0] CORE_RST = 16'h0020;
	localparam logic [22:0] PC_STEP = 23'h000002;
	localparam logic [15:0] SP_STEP = 16'h0004;
endpackage

// File: dsp_cpu_programmer_model.sv
// CPU programmer's model: register file, address generators and loop engine
// Summary of operation
// - Data path is 16 bits; fetch words are 24 bits wide.
// - Program counter is 23 bits, covering 4M program words of 24 bits.
// - Each retired instruction advances the fetch address by one word, unless a repeat holds it or a loop end branches back.
// - Repeat and loop run without software; an interrupt may preempt either.
// - Sixteen 16-bit working registers serve as data, address or offset.
// - Last working register is the stack pointer for interrupt context.
// - One execution unit; non-signal-processing variants omit those features.
// - 8 Kbyte base data space split over X and Y generators.
// - Microcontroller class uses X only; dual reads use X and Y.
// - Upper 4 Kbytes optionally map onto program space at 16K boundaries.
// - Read or write page joins base address to form extended address.
// - Circular addressing on X and Y with no software boundary checks.
// - X generator supports bit-reversed addressing; absent without DSP.
// - Register indirect with post-modify by offset; other modes decode outside this block.
// - Every model register is readable as a mapped location; all but the loop start pair are also writable, though a status write only clears the stack error.
// - Two 40-bit accumulators are held when DSP support is present.
// - Loop state held: counts, start and end addresses, limit, table page.
// - Loop start address registers ignore software writes.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dsp_cpu_programmer_model #(
	parameter bit DSP_EN = 1'b1
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Execution events
	input wire logic step_i,
	input wire logic irq_take_i,
	input wire logic [dsp_cpu_pkg::PC_W-1:0] irq_vec_i,
	output logic [dsp_cpu_pkg::PC_W-1:0] fetch_addr_o,
	output logic stack_err_o,
	// Address generator request
	input wire logic ag_req_i,
	input wire logic ag_write_i,
	input wire logic ag_dual_i,
	input wire logic [3:0] ag_xreg_i,
	input wire logic [15:0] ag_xoff_i,
	input wire logic [3:0] ag_yreg_i,
	input wire logic [15:0] ag_yoff_i,
	output logic ag_valid_o,
	output logic [15:0] x_addr_o,
	output logic [15:0] y_addr_o,
	output logic [23:0] ext_addr_o,
	output logic [dsp_cpu_pkg::PC_W-1:0] pwin_addr_o,
	output logic pwin_hit_o
);
	import dsp_cpu_pkg::*;

	// Checks sample on the core clock and sleep during reset
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	typedef struct packed {
		logic [NUM_W-1:0][DATA_W-1:0] w;
		logic [ACC_W-1:0] acc_a;
		logic [ACC_W-1:0] acc_b;
		logic [PC_W-1:0] pc;
		logic [15:0] flags;
		logic [15:0] stklim;
		logic [15:0] tblpg;
		logic [15:0] rdpg;
		logic [15:0] wrpg;
		logic [15:0] rcnt;
		logic [15:0] dcnt;
		logic [6:0] ls_h;
		logic [15:0] ls_l;
		logic [6:0] le_h;
		logic [15:0] le_l;
		logic [15:0] core;
		logic [15:0] xms;
		logic [15:0] xme;
		logic [15:0] yms;
		logic [15:0] yme;
		logic [15:0] mctl;
		logic [15:0] brev;
		logic rep_act;
		logic do_act;
		logic stk_err;
		logic [31:0] rdata;
		logic slverr;
		logic vld;
		logic [15:0] xa;
		logic [15:0] ya;
		logic [23:0] ext;
		logic [PC_W-1:0] pwin;
		logic pwin_hit;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic wr_en;
	logic [5:0] idx;
	logic [15:0] wd;

	// Circular step: wraps past either bound without software checks
	function automatic logic [15:0] mod_adv(input logic [15:0] a,
		input logic [15:0] off, input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] n;
		n = a + off;
		if (!off[15] && a <= hi && n > hi)
			mod_adv = lo + (n - hi - 16'h0001);
		else if (off[15] && a >= lo && n < lo)
			mod_adv = hi - (lo - n - 16'h0001);
		else
			mod_adv = n;
	endfunction

	function automatic logic [15:0] rev16(input logic [15:0] a);
		for (int i = 0; i < 16; i++)
			rev16[i] = a[15-i];
	endfunction

	// Read mux; unmapped indices flag an error
	function automatic logic [32:0] reg_read(input state_s s,
		input logic [5:0] i);
		logic [15:0] fl;
		fl = s.flags;
		fl[FLG_DA] = s.do_act;
		fl[FLG_RA] = s.rep_act;
		reg_read = '0;
		if (i < 6'h10)
			reg_read[15:0] = s.w[i[3:0]];
		else
			unique case (i)
				IDX_ACC0_L: reg_read[15:0] = s.acc_a[15:0];
				IDX_ACC0_H: reg_read[15:0] = s.acc_a[31:16];
				IDX_ACC0_U: reg_read[7:0] = s.acc_a[39:32];
				IDX_ACC1_L: reg_read[15:0] = s.acc_b[15:0];
				IDX_ACC1_H: reg_read[15:0] = s.acc_b[31:16];
				IDX_ACC1_U: reg_read[7:0] = s.acc_b[39:32];
				IDX_PC_L: reg_read[15:0] = s.pc[15:0];
				IDX_PC_H: reg_read[6:0] = s.pc[22:16];
				IDX_FLAGS: reg_read[15:0] = fl;
				IDX_STKLIM: reg_read[15:0] = s.stklim;
				IDX_TBLPG: reg_read[15:0] = s.tblpg;
				IDX_RDPG: reg_read[15:0] = s.rdpg;
				IDX_WRPG: reg_read[15:0] = s.wrpg;
				IDX_RCNT: reg_read[15:0] = s.rcnt;
				IDX_DCNT: reg_read[15:0] = s.dcnt;
				IDX_LS_H: reg_read[6:0] = s.ls_h;
				IDX_LS_L: reg_read[15:0] = s.ls_l;
				IDX_LE_H: reg_read[6:0] = s.le_h;
				IDX_LE_L: reg_read[15:0] = s.le_l;
				IDX_CORE: reg_read[15:0] = s.core;
				IDX_XMS: reg_read[15:0] = s.xms;
				IDX_XME: reg_read[15:0] = s.xme;
				IDX_YMS: reg_read[15:0] = s.yms;
				IDX_YME: reg_read[15:0] = s.yme;
				IDX_MCTL: reg_read[15:0] = s.mctl;
				IDX_BREV: reg_read[15:0] = s.brev;
				IDX_LCMD: reg_read[15:0] = 16'h0000;
				IDX_STAT: reg_read[2:0] = {s.do_act, s.rep_act, s.stk_err};
				default: reg_read[32] = 1'b1;
			endcase
	endfunction

	assign idx = paddr_i[7:2];
	assign wd = pwdata_i[15:0];
	assign wr_en = psel_i && penable_i && pwrite_i && !st_r.slverr;

	always_comb
	begin
		logic [15:0] xw;
		logic [15:0] yw;
		logic [15:0] xn;
		logic [15:0] yn;
		logic [15:0] ea;
		logic [15:0] pg;
		logic [32:0] rd;
		logic [15:0] sp_n;
		st_nxt = st_r;
		xw = st_r.w[ag_xreg_i];
		yw = st_r.w[ag_yreg_i];
		ea = xw + ag_xoff_i;
		xn = ea;
		yn = yw + ag_yoff_i;
		pg = ag_write_i ? st_r.wrpg : st_r.rdpg;
		sp_n = st_r.w[15] + SP_STEP;
		rd = reg_read(st_r, idx);
		// Read data is captured in setup so the access phase ends at once
		if (psel_i && !penable_i)
		begin
			st_nxt.rdata = pwrite_i ? 32'h00000000 : rd[31:0];
			st_nxt.slverr = rd[32];
		end
		// Instruction flow: interrupt outranks retirement
		if (irq_take_i)
		begin
			st_nxt.pc = irq_vec_i;
			st_nxt.w[15] = sp_n;
			if (sp_n > st_r.stklim)
				st_nxt.stk_err = 1'b1;
		end
		else if (step_i)
		begin
			if (st_r.rep_act)
			begin
				if (st_r.rcnt == 16'h0000)
				begin
					st_nxt.rep_act = 1'b0;
					st_nxt.pc = st_r.pc + PC_STEP;
				end
				else
					st_nxt.rcnt = st_r.rcnt - 16'h0001;
			end
			else if (st_r.do_act && st_r.pc == {st_r.le_h, st_r.le_l})
			begin
				if (st_r.dcnt == 16'h0000)
				begin
					st_nxt.do_act = 1'b0;
					st_nxt.pc = st_r.pc + PC_STEP;
				end
				else
				begin
					st_nxt.dcnt = st_r.dcnt - 16'h0001;
					st_nxt.pc = {st_r.ls_h, st_r.ls_l};
				end
			end
			else
				st_nxt.pc = st_r.pc + PC_STEP;
		end
		// Address generators, register indirect with post-modify by offset
		st_nxt.vld = ag_req_i;
		if (ag_req_i)
		begin
			if (DSP_EN && st_r.mctl[MCTL_XM] && ag_xreg_i == st_r.mctl[7:4])
				xn = mod_adv(xw, ag_xoff_i, st_r.xms, st_r.xme);
			else if (DSP_EN && st_r.mctl[MCTL_BR]
				&& ag_xreg_i == st_r.mctl[15:12])
				xn = rev16(rev16(xw) + rev16(st_r.brev));
			st_nxt.xa = xw;
			st_nxt.w[ag_xreg_i] = xn;
			st_nxt.ext = {pg[PAGE_W-1:0], xw[BASE_W-1:0]};
			st_nxt.pwin_hit = st_r.core[CORE_PWIN] && xw[BASE_W-1];
			st_nxt.pwin = {st_r.rdpg[PWIN_PG_W-1:0], 3'b000,
				xw[PWIN_OFF_W:1]};
			st_nxt.ya = 16'h0000;
			if (DSP_EN && ag_dual_i)
			begin
				if (st_r.mctl[MCTL_YM] && ag_yreg_i == st_r.mctl[11:8])
					yn = mod_adv(yw, ag_yoff_i, st_r.yms, st_r.yme);
				st_nxt.ya = yw;
				st_nxt.w[ag_yreg_i] = yn;
			end
		end
		// Software writes land after hardware updates and win, except a stack error clear in a cycle that raises a new error
		if (wr_en)
		begin
			if (idx < 6'h10)
				st_nxt.w[idx[3:0]] = wd;
			else
				unique case (idx)
					IDX_ACC0_L: st_nxt.acc_a[15:0] = wd;
					IDX_ACC0_H: st_nxt.acc_a[31:16] = wd;
					IDX_ACC0_U: st_nxt.acc_a[39:32] = wd[7:0];
					IDX_ACC1_L: st_nxt.acc_b[15:0] = wd;
					IDX_ACC1_H: st_nxt.acc_b[31:16] = wd;
					IDX_ACC1_U: st_nxt.acc_b[39:32] = wd[7:0];
					IDX_PC_L: st_nxt.pc[15:0] = {wd[15:1], 1'b0};
					IDX_PC_H: st_nxt.pc[22:16] = wd[6:0];
					IDX_FLAGS: st_nxt.flags = wd;
					IDX_STKLIM: st_nxt.stklim = wd;
					IDX_TBLPG: st_nxt.tblpg = wd;
					IDX_RDPG: st_nxt.rdpg = wd;
					IDX_WRPG: st_nxt.wrpg = wd;
					IDX_RCNT: st_nxt.rcnt = wd;
					IDX_DCNT: st_nxt.dcnt = wd;
					IDX_LE_H: st_nxt.le_h = wd[6:0];
					IDX_LE_L: st_nxt.le_l = wd;
					IDX_CORE: st_nxt.core = wd;
					IDX_XMS: st_nxt.xms = wd;
					IDX_XME: st_nxt.xme = wd;
					IDX_YMS: st_nxt.yms = wd;
					IDX_YME: st_nxt.yme = wd;
					IDX_MCTL: st_nxt.mctl = wd;
					IDX_BREV: st_nxt.brev = wd;
					IDX_LCMD:
					begin
						if (wd[0])
							st_nxt.rep_act = 1'b1;
						if (wd[1] && DSP_EN)
						begin
							st_nxt.do_act = 1'b1;
							{st_nxt.ls_h, st_nxt.ls_l} = st_r.pc + PC_STEP;
						end
					end
					IDX_STAT:
						if (wd[STAT_STK] && !(irq_take_i && sp_n > st_r.stklim))
							st_nxt.stk_err = 1'b0;
					default: ;
				endcase
		end
		if (!DSP_EN)
		begin
			st_nxt.acc_a = '0;
			st_nxt.acc_b = '0;
			st_nxt.dcnt = 16'h0000;
			st_nxt.mctl = 16'h0000;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
			st_r.w[15] <= SP_RST;
			st_r.stklim <= STKLIM_RST;
			st_r.core <= CORE_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign prdata_o = st_r.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && st_r.slverr;
	assign fetch_addr_o = st_r.pc;
	assign stack_err_o = st_r.stk_err;
	assign ag_valid_o = st_r.vld;
	assign x_addr_o = st_r.xa;
	assign y_addr_o = st_r.ya;
	assign ext_addr_o = st_r.ext;
	assign pwin_addr_o = st_r.pwin;
	assign pwin_hit_o = st_r.pwin_hit;

	ro_start_a: assert property (
		wr_en && (idx == IDX_LS_H || idx == IDX_LS_L) && !step_i
		|=> $stable({st_r.ls_h, st_r.ls_l}))
		else $error("Loop start register changed by a write");
	sp_irq_a: assert property (
		irq_take_i && !(wr_en && idx == 6'h0f) && !ag_req_i
		|=> st_r.w[15] == $past(st_r.w[15]) + SP_STEP)
		else $error("Stack pointer not advanced on interrupt");
	rep_hold_a: assert property (
		step_i && !irq_take_i && st_r.rep_act && st_r.rcnt != 16'h0000
		&& !wr_en |=> fetch_addr_o == $past(fetch_addr_o))
		else $error("Repeat did not hold the fetch address");
	pc_step_a: assert property (
		step_i && !irq_take_i && !st_r.rep_act && !st_r.do_act && !wr_en
		|=> fetch_addr_o == $past(fetch_addr_o) + PC_STEP)
		else $error("Fetch address did not advance one word");
	loop_back_a: assert property (
		step_i && !irq_take_i && !st_r.rep_act && st_r.do_act && !wr_en
		&& st_r.pc == {st_r.le_h, st_r.le_l} && st_r.dcnt != 16'h0000
		|=> fetch_addr_o == {st_r.ls_h, st_r.ls_l})
		else $error("Loop end did not branch to loop start");
	pwin_map_a: assert property (
		ag_req_i && st_r.core[CORE_PWIN] && st_r.w[ag_xreg_i][BASE_W-1]
		|=> pwin_hit_o && pwin_addr_o[13:11] == 3'b000)
		else $error("Program space window not mapped");
	ext_page_a: assert property (
		ag_req_i && ag_write_i |=> ag_valid_o
		&& ext_addr_o[23:13] == $past(st_r.wrpg[PAGE_W-1:0]))
		else $error("Extended address used the wrong page");
	dual_off_a: assert property (
		ag_req_i && !ag_dual_i |=> y_addr_o == 16'h0000)
		else $error("Y generator used without a dual read");
endmodule // dsp_cpu_programmer_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the CPU programmer's model block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dsp_cpu_pkg::*;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic pready_o, pslverr_o, stack_err_o, ag_valid_o, pwin_hit_o;
	logic step_i = 1'b0, irq_take_i = 1'b0;
	logic [PC_W-1:0] irq_vec_i = '0, fetch_addr_o, pwin_addr_o;
	logic ag_req_i = 1'b0, ag_write_i = 1'b0, ag_dual_i = 1'b0;
	logic [3:0] ag_xreg_i = 4'h0, ag_yreg_i = 4'h0;
	logic [15:0] ag_xoff_i = 16'h0, ag_yoff_i = 16'h0, x_addr_o, y_addr_o;
	logic [23:0] ext_addr_o;
	logic [31:0] rd;
	logic err;
	logic [22:0] loop_pc [5];
	int n_mismatch = 0;
	int comparisons = 0;

	always #4 core_clk_i = ~core_clk_i;

	dsp_cpu_programmer_model #(.DSP_EN(1'b1)) dut (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.step_i(step_i), .irq_take_i(irq_take_i), .irq_vec_i(irq_vec_i),
		.fetch_addr_o(fetch_addr_o), .stack_err_o(stack_err_o),
		.ag_req_i(ag_req_i), .ag_write_i(ag_write_i),
		.ag_dual_i(ag_dual_i), .ag_xreg_i(ag_xreg_i),
		.ag_xoff_i(ag_xoff_i), .ag_yreg_i(ag_yreg_i),
		.ag_yoff_i(ag_yoff_i), .ag_valid_o(ag_valid_o),
		.x_addr_o(x_addr_o), .y_addr_o(y_addr_o), .ext_addr_o(ext_addr_o),
		.pwin_addr_o(pwin_addr_o), .pwin_hit_o(pwin_hit_o)
	);

	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request is held until the edge that sees pready high
	task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		@(posedge core_clk_i);
		while (pready_o !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				n_mismatch++;
				end_sim;
			end
			@(posedge core_clk_i);
		end
		// Taken at the edge that sees pready, before the design updates
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		// Let the write settle before any caller looks at outputs
		@(negedge core_clk_i);
	endtask

	task wr(input logic [5:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask

	task rchk(input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask

	// Interrupt outranks step, so the two are never raised together here
	task pulse(input logic irq, input logic [22:0] vec);
		@(posedge core_clk_i);
		step_i <= ~irq;
		irq_take_i <= irq;
		irq_vec_i <= vec;
		@(posedge core_clk_i);
		step_i <= 1'b0;
		irq_take_i <= 1'b0;
		@(negedge core_clk_i);
	endtask

	task ag_req(input logic [3:0] xr, input logic [15:0] xo,
		input logic [3:0] yr, input logic [15:0] yo, input logic dual,
		input logic w);
		@(posedge core_clk_i);
		ag_req_i <= 1'b1;
		ag_xreg_i <= xr;
		ag_xoff_i <= xo;
		ag_yreg_i <= yr;
		ag_yoff_i <= yo;
		ag_dual_i <= dual;
		ag_write_i <= w;
		@(posedge core_clk_i);
		ag_req_i <= 1'b0;
		@(negedge core_clk_i);
		chk({31'h0, ag_valid_o}, 32'h1);
	endtask

	initial
	begin
		repeat (3) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		rchk(IDX_W0 + 6'd15, {16'h0, SP_RST});
		rchk(IDX_STKLIM, {16'h0, STKLIM_RST});
		rchk(IDX_CORE, {16'h0, CORE_RST});
		rchk(IDX_RCNT, 32'h0);
		$display("test reset_values done");
		for (int i = 0; i < 16; i++)
		begin
			wr(IDX_W0 + 6'(i), {16'hffff, 16'ha500 | 16'(i)});
			rchk(IDX_W0 + 6'(i), {16'h0, 16'ha500 | 16'(i)});
		end
		wr(IDX_W0 + 6'd15, {16'h0, SP_RST});
		wr(IDX_ACC0_U, 32'hffff);
		rchk(IDX_ACC0_U, 32'h00ff);
		wr(IDX_ACC1_H, 32'h5a5a);
		rchk(IDX_ACC1_H, 32'h5a5a);
		wr(IDX_LS_L, 32'hbeef);
		rchk(IDX_LS_L, 32'h0);
		wr(IDX_LS_H, 32'h007f);
		rchk(IDX_LS_H, 32'h0);
		apb(1'b0, 6'h2c, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 6'h3f, 32'h1);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, IDX_TBLPG, 32'h0);
		chk({31'h0, err}, 32'h0);
		$display("test register_access done");
		wr(IDX_PC_L, 32'h1235);
		wr(IDX_PC_H, 32'h007f);
		chk({9'h0, fetch_addr_o}, 32'h7f1234);
		pulse(1'b0, 23'h0);
		chk({9'h0, fetch_addr_o}, 32'h7f1236);
		$display("test program_counter done");
		// A pointer equal to the limit is still legal; one past it is not
		wr(IDX_STKLIM, 32'h1004);
		pulse(1'b1, 23'h000100);
		chk({9'h0, fetch_addr_o}, 32'h100);
		chk({31'h0, stack_err_o}, 32'h0);
		rchk(IDX_W0 + 6'd15, 32'h1004);
		pulse(1'b1, 23'h000200);
		chk({31'h0, stack_err_o}, 32'h1);
		rchk(IDX_W0 + 6'd15, 32'h1008);
		rchk(IDX_STAT, 32'h1);
		wr(IDX_STAT, 32'h1);
		chk({31'h0, stack_err_o}, 32'h0);
		$display("test interrupt_stack done");
		wr(IDX_RCNT, 32'h1);
		wr(IDX_LCMD, 32'h1);
		rchk(IDX_FLAGS, 32'h0010);
		pulse(1'b0, 23'h0);
		chk({9'h0, fetch_addr_o}, 32'h200);
		rchk(IDX_RCNT, 32'h0);
		pulse(1'b0, 23'h0);
		chk({9'h0, fetch_addr_o}, 32'h202);
		rchk(IDX_FLAGS, 32'h0);
		$display("test repeat done");
		wr(IDX_LE_L, 32'h0206);
		wr(IDX_LE_H, 32'h0);
		wr(IDX_DCNT, 32'h1);
		wr(IDX_LCMD, 32'h2);
		rchk(IDX_LS_L, 32'h0204);
		rchk(IDX_LS_H, 32'h0);
		wr(IDX_LS_L, 32'hdead);
		rchk(IDX_LS_L, 32'h0204);
		rchk(IDX_FLAGS, 32'h0200);
		loop_pc = '{23'h204, 23'h206, 23'h204, 23'h206, 23'h208};
		for (int i = 0; i < 5; i++)
		begin
			pulse(1'b0, 23'h0);
			chk({9'h0, fetch_addr_o}, {9'h0, loop_pc[i]});
		end
		rchk(IDX_FLAGS, 32'h0);
		$display("test hardware_loop done");
		wr(IDX_W0 + 6'd1, 32'h0100);
		wr(IDX_RDPG, 32'h5);
		wr(IDX_WRPG, 32'h6);
		ag_req(4'd1, 16'h0002, 4'd0, 16'h0, 1'b0, 1'b0);
		chk({16'h0, x_addr_o}, 32'h0100);
		chk({16'h0, y_addr_o}, 32'h0);
		chk({8'h0, ext_addr_o}, 32'h00a100);
		chk({31'h0, pwin_hit_o}, 32'h0);
		rchk(IDX_W0 + 6'd1, 32'h0102);
		wr(IDX_W0 + 6'd4, 32'h0800);
		ag_req(4'd1, 16'h0002, 4'd4, 16'hfffe, 1'b1, 1'b1);
		chk({16'h0, x_addr_o}, 32'h0102);
		chk({16'h0, y_addr_o}, 32'h0800);
		chk({8'h0, ext_addr_o}, 32'h00c102);
		rchk(IDX_W0 + 6'd4, 32'h07fe);
		wr(IDX_CORE, 32'h0024);
		wr(IDX_W0 + 6'd2, 32'h1802);
		ag_req(4'd2, 16'h0, 4'd0, 16'h0, 1'b0, 1'b0);
		chk({31'h0, pwin_hit_o}, 32'h1);
		chk({9'h0, pwin_addr_o}, 32'h14401);
		chk({8'h0, ext_addr_o}, 32'h00b802);
		// Byte buffers 0x100-0x107 on X and 0x800-0x807 on Y wrap past the top and the bottom respectively
		wr(IDX_XMS, 32'h0100);
		wr(IDX_XME, 32'h0107);
		wr(IDX_YMS, 32'h0800);
		wr(IDX_YME, 32'h0807);
		wr(IDX_W0 + 6'd3, 32'h0106);
		wr(IDX_W0 + 6'd4, 32'h0800);
		wr(IDX_W0 + 6'd5, 32'h0);
		wr(IDX_BREV, 32'h0008);
		wr(IDX_MCTL, 32'h5437);
		ag_req(4'd3, 16'h0002, 4'd4, 16'hfffe, 1'b1, 1'b0);
		chk({16'h0, x_addr_o}, 32'h0106);
		chk({16'h0, y_addr_o}, 32'h0800);
		rchk(IDX_W0 + 6'd3, 32'h0100);
		rchk(IDX_W0 + 6'd4, 32'h0806);
		ag_req(4'd5, 16'h0, 4'd0, 16'h0, 1'b0, 1'b0);
		rchk(IDX_W0 + 6'd5, 32'h0008);
		ag_req(4'd5, 16'h0, 4'd0, 16'h0, 1'b0, 1'b0);
		chk({16'h0, x_addr_o}, 32'h0008);
		rchk(IDX_W0 + 6'd5, 32'h0004);
		$display("test address_generator done");
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
